// ### design/alc_gain.sv
/*
  Automatic level control gain engine for one stereo path: limiter,
  recovery wait, normal and fast recovery, soft release to manual volume,
  register port and coarse gain readback.
  Assumes the downstream stage presents each output sample with a one-cycle
  valid at fs, on the same clock, and applies the common gain it is given.
*/
// The strobed register port and the placing of the registers were decided locally.
// Contract
// R01: Level control acts only while the enable bit is set.
// R02: Path bit picks record or playback volumes and ceiling.
// R03: Output over detection level triggers shared attenuation of the volume.
// R04: A limiter event attenuates once per sample for sixteen samples.
// R05: Step is 0.38142, 0.06812 or 0.02548 dB by sample level.
// R06: After a sequence, a new excursion starts another sequence.
// R07: Threshold select sets detection and recovery reset levels.
// R08: Recovery wait is 128, 256, 512 or 1024 samples.
// R09: Quiet for the whole wait, gain rises every sample.
// R10: Recovery never raises the gain past the ceiling.
// R11: Three-bit select gives the normal recovery step.
// R12: Level between reset and detection restarts the wait timer.
// R13: Wait timer counts while the level is below reset level.
// R14: Two-bit select gives the fast recovery step.
// R15: Record ceiling is 8-bit code in 0.375 dB steps.
// R16: Playback ceiling uses the playback ceiling code likewise.
// R17: Live gain is copied to the readback field.
// R18: Readback reports the gain in coarse bins.
// R19: Software changes settings only with level control disabled.
// R20: After disable, gain glides softly to the manual volume.
// R21: Quick return below reset level selects the fast step.
// R22: Working gain keeps a fine fraction below 0.375 dB.
`timescale 1ns/1ps
`default_nettype none

module alc_gain (
  input wire logic clock,
  input wire logic reset_n,
  input wire alc_pkg::alc_busreq_t busReq,
  output logic [15:0] rdData,
  input wire alc_pkg::alc_sample_t sampleIn,
  output alc_pkg::alc_gain_t gainOut,
  output logic limitActive
);

  // ------------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------------
  function automatic logic [24:0] absMag(input logic signed [24:0] s);
    absMag = s[24] ? 25'(-s) : 25'(s);
  endfunction

  function automatic logic [7:0] binCode(input logic [7:0] c);
    if (c == 8'h00) binCode = 8'h00;
    else if (c >= 8'hED) binCode = 8'hED;
    else if (c >= 8'h21) binCode = ((c - 8'h01) & 8'hFC) + 8'h01;
    else if (c >= 8'h19) binCode = 8'h19;
    else if (c >= 8'h11) binCode = 8'h11;
    else binCode = 8'h01;
  endfunction

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [10:0] ctrl_q;
  logic [7:0] recCeil_q;
  logic [7:0] pbCeil_q;
  logic [15:0] recVol_q;
  logic [15:0] pbVol_q;
  logic [15:0] rdData_q;
  logic [7:0] readback_q;

  wire wrCtrl = busReq.wr && busReq.addr == alc_pkg::ADDR_CTRL;
  wire wrRecCeil = busReq.wr && busReq.addr == alc_pkg::ADDR_REC_CEIL;
  wire wrPbCeil = busReq.wr && busReq.addr == alc_pkg::ADDR_PB_CEIL;
  wire wrRecVol = busReq.wr && busReq.addr == alc_pkg::ADDR_REC_VOL;
  wire wrPbVol = busReq.wr && busReq.addr == alc_pkg::ADDR_PB_VOL;

  wire ctrlEn = ctrl_q[alc_pkg::CTRL_EN_BIT];
  wire pathRecord = ctrl_q[alc_pkg::CTRL_PATH_BIT];
  wire [1:0] limitThresholdSel = ctrl_q[alc_pkg::CTRL_LMTH_LSB +: 2];
  wire [1:0] recoveryWaitSel = ctrl_q[alc_pkg::CTRL_WTM_LSB +: 2];
  wire [2:0] recoveryStepSel = ctrl_q[alc_pkg::CTRL_RGAIN_LSB +: 3];
  wire [1:0] fastStepSel = ctrl_q[alc_pkg::CTRL_RFST_LSB +: 2];

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  alc_pkg::alc_state_t state_q, state_d;
  logic [21:0] gain_q, gain_d;
  logic [4:0] limCnt_q, limCnt_d;
  logic [10:0] waitCnt_q, waitCnt_d;
  logic fast_q, fast_d;

  // ------------------------------------------------------------------
  // Path selection and level decode
  // ------------------------------------------------------------------
  wire [7:0] gainCeiling = pathRecord ? recCeil_q : pbCeil_q; // [R02] [R15] [R16]
  wire [7:0] manualVol = pathRecord ? recVol_q[7:0] : pbVol_q[7:0]; // [R02]
  wire [21:0] ceilFine = {gainCeiling, {alc_pkg::FRAC_W{1'b0}}};
  wire [21:0] manualFine = {manualVol, {alc_pkg::FRAC_W{1'b0}}};

  wire [24:0] magL = absMag(sampleIn.left);
  wire [24:0] magR = absMag(sampleIn.right);
  wire [24:0] mag = (magL > magR) ? magL : magR; // [R03]

  logic [24:0] detLevel;
  logic [24:0] rstLevel;
  always_comb begin // [R07]
    case (limitThresholdSel)
      2'b00: begin
        detLevel = alc_pkg::LVL_M2_5;
        rstLevel = alc_pkg::LVL_M4_1;
      end
      2'b01: begin
        detLevel = alc_pkg::LVL_M4_1;
        rstLevel = alc_pkg::LVL_M6_0;
      end
      2'b10: begin
        detLevel = alc_pkg::LVL_M6_0;
        rstLevel = alc_pkg::LVL_M8_5;
      end
      default: begin
        detLevel = alc_pkg::LVL_M8_5;
        rstLevel = alc_pkg::LVL_M12;
      end
    endcase
  end

  wire overDet = mag > detLevel;
  wire belowRst = mag < rstLevel;

  // Attenuation grows with how far the current sample overshoots
  wire [21:0] attStep = (mag >= alc_pkg::LVL_P0_53) ? alc_pkg::ATT_BIG : // [R05]
                        (mag > alc_pkg::LVL_M1_16) ? alc_pkg::ATT_MID :
                        alc_pkg::ATT_SMALL;
  wire [21:0] gainAtt = (gain_q > attStep) ? gain_q - attStep : 22'h000000;

  logic [21:0] normStep;
  always_comb begin // [R11]
    case (recoveryStepSel)
      3'd0: normStep = 22'd183;
      3'd1: normStep = 22'd92;
      3'd2: normStep = 22'd48;
      3'd3: normStep = 22'd22;
      3'd4: normStep = 22'd13;
      3'd5: normStep = 22'd4;
      3'd6: normStep = 22'd3;
      default: normStep = 22'd1;
    endcase
  end

  logic [21:0] fastStep;
  always_comb begin // [R14]
    case (fastStepSel)
      2'd0: fastStep = 22'd140;
      2'd1: fastStep = 22'd183;
      2'd2: fastStep = 22'd280;
      default: fastStep = 22'd555;
    endcase
  end

  wire [21:0] recStep = fast_q ? fastStep : normStep; // [R21]
  wire [22:0] gainSum = {1'b0, gain_q} + {1'b0, recStep}; // [R22]
  // Gain above the ceiling is held, never pulled down by recovery
  wire [21:0] gainRec = (gain_q >= ceilFine) ? gain_q : // [R10]
                        (gainSum > {1'b0, ceilFine}) ? ceilFine : gainSum[21:0];

  wire [10:0] waitLast = 11'((alc_pkg::WAIT_BASE << recoveryWaitSel) - 1); // [R08]

  wire [21:0] softUp = (manualFine - gain_q > alc_pkg::SOFT_STEP) ?
                       gain_q + alc_pkg::SOFT_STEP : manualFine;
  wire [21:0] softDn = (gain_q - manualFine > alc_pkg::SOFT_STEP) ?
                       gain_q - alc_pkg::SOFT_STEP : manualFine;
  wire [21:0] gainSoft = (gain_q < manualFine) ? softUp : softDn;

  // ------------------------------------------------------------------
  // Per-sample sequencing
  // ------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    gain_d = gain_q;
    limCnt_d = limCnt_q;
    waitCnt_d = waitCnt_q;
    fast_d = fast_q;
    if (sampleIn.valid) begin
      if (!ctrlEn) begin // [R01]
        state_d = alc_pkg::ST_OFF;
        gain_d = gainSoft; // [R20]
        fast_d = 1'b0;
      end else begin
        case (state_q)
          alc_pkg::ST_OFF: begin
            state_d = alc_pkg::ST_WAIT;
            waitCnt_d = 11'h000;
          end
          alc_pkg::ST_LIMIT: begin
            gain_d = gainAtt; // [R04] [R05]
            if (belowRst) fast_d = 1'b1; // [R21]
            if (limCnt_q == 5'(alc_pkg::LIMIT_SAMPLES - 1)) begin // [R04]
              state_d = alc_pkg::ST_WAIT;
              waitCnt_d = 11'h000;
            end else begin
              limCnt_d = limCnt_q + 5'h01;
            end
          end
          alc_pkg::ST_WAIT: begin
            if (overDet) begin // [R03] [R06]
              state_d = alc_pkg::ST_LIMIT;
              gain_d = gainAtt;
              limCnt_d = 5'h01;
              fast_d = 1'b0;
            end else if (!belowRst) begin
              waitCnt_d = 11'h000; // [R12]
            end else if (waitCnt_q == waitLast) begin
              state_d = alc_pkg::ST_RECOVER; // [R09]
            end else begin
              waitCnt_d = waitCnt_q + 11'h001; // [R13]
            end
          end
          alc_pkg::ST_RECOVER: begin
            if (overDet) begin // [R06]
              state_d = alc_pkg::ST_LIMIT;
              gain_d = gainAtt;
              limCnt_d = 5'h01;
              fast_d = 1'b0;
            end else if (!belowRst) begin // [R12]
              state_d = alc_pkg::ST_WAIT;
              waitCnt_d = 11'h000;
            end else begin
              gain_d = gainRec; // [R09] [R10]
            end
          end
          default: state_d = alc_pkg::ST_OFF;
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_q <= alc_pkg::ST_OFF;
      gain_q <= {alc_pkg::PB_VOL_RESET, {alc_pkg::FRAC_W{1'b0}}};
      limCnt_q <= 5'h00;
      waitCnt_q <= 11'h000;
      fast_q <= 1'b0;
    end else begin
      state_q <= state_d;
      gain_q <= gain_d;
      limCnt_q <= limCnt_d;
      waitCnt_q <= waitCnt_d;
      fast_q <= fast_d;
    end
  end

  // ------------------------------------------------------------------
  // Register port
  // ------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ctrl_q <= alc_pkg::CTRL_RESET;
      recCeil_q <= alc_pkg::CEIL_RESET;
      pbCeil_q <= alc_pkg::CEIL_RESET;
      recVol_q <= {alc_pkg::REC_VOL_RESET, alc_pkg::REC_VOL_RESET};
      pbVol_q <= {alc_pkg::PB_VOL_RESET, alc_pkg::PB_VOL_RESET};
    end else begin
      if (wrCtrl) ctrl_q <= busReq.wdata[10:0];
      if (wrRecCeil) recCeil_q <= busReq.wdata[7:0];
      if (wrPbCeil) pbCeil_q <= busReq.wdata[7:0];
      if (wrRecVol) recVol_q <= busReq.wdata;
      if (wrPbVol) pbVol_q <= busReq.wdata;
    end
  end

  logic [15:0] rdMux;
  always_comb begin
    case (busReq.addr)
      alc_pkg::ADDR_CTRL: rdMux = {5'h00, ctrl_q};
      alc_pkg::ADDR_REC_CEIL: rdMux = {8'h00, recCeil_q};
      alc_pkg::ADDR_PB_CEIL: rdMux = {8'h00, pbCeil_q};
      alc_pkg::ADDR_REC_VOL: rdMux = recVol_q;
      alc_pkg::ADDR_PB_VOL: rdMux = pbVol_q;
      alc_pkg::ADDR_STATUS: rdMux = {5'h00, 2'(state_q), fast_q, readback_q};
      default: rdMux = 16'h0000;
    endcase
  end

  // Readback tracks the live gain every cycle, coarse binned
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rdData_q <= 16'h0000;
      readback_q <= 8'h00;
    end else begin
      rdData_q <= busReq.rd ? rdMux : 16'h0000;
      readback_q <= binCode(gain_q[21 -: 8]); // [R17] [R18]
    end
  end

  assign rdData = rdData_q;
  assign gainOut = gain_q;
  assign limitActive = state_q == alc_pkg::ST_LIMIT;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  wire smp = sampleIn.valid;

  sequence s_last_limit;
    smp && ctrlEn && state_q == alc_pkg::ST_LIMIT &&
      limCnt_q == 5'(alc_pkg::LIMIT_SAMPLES - 1);
  endsequence

  sequence s_wait_entered;
    ##1 state_q == alc_pkg::ST_WAIT && waitCnt_q == 11'h000;
  endsequence

  property p_off_when_disabled;
    @(posedge clock) disable iff (!reset_n)
      smp && !ctrlEn |=> state_q == alc_pkg::ST_OFF && !limitActive;
  endproperty
  a_off_when_disabled: assert property (p_off_when_disabled) // [R01]
    else $error("level control active while disabled");

  property p_limit_ends;
    @(posedge clock) disable iff (!reset_n)
      s_last_limit |-> s_wait_entered;
  endproperty
  a_limit_ends: assert property (p_limit_ends) // [R04]
    else $error("limiter did not end after sixteen samples");

  property p_big_step;
    @(posedge clock) disable iff (!reset_n)
      smp && ctrlEn && state_q == alc_pkg::ST_LIMIT && mag >= alc_pkg::LVL_P0_53 &&
      gain_q > alc_pkg::ATT_BIG |=> gain_q == $past(gain_q) - alc_pkg::ATT_BIG;
  endproperty
  a_big_step: assert property (p_big_step) // [R05]
    else $error("wrong attenuation for overshoot");

  property p_restart_limit;
    @(posedge clock) disable iff (!reset_n)
      smp && ctrlEn && state_q == alc_pkg::ST_WAIT && overDet |=>
      limitActive && limCnt_q == 5'h01;
  endproperty
  a_restart_limit: assert property (p_restart_limit) // [R06]
    else $error("excursion did not start a limiter sequence");

  property p_wait_done;
    @(posedge clock) disable iff (!reset_n)
      smp && ctrlEn && state_q == alc_pkg::ST_WAIT && belowRst && !overDet &&
      waitCnt_q == waitLast |=> state_q == alc_pkg::ST_RECOVER;
  endproperty
  a_wait_done: assert property (p_wait_done) // [R08]
    else $error("recovery did not begin after the wait");

  property p_rec_ceiling;
    @(posedge clock) disable iff (!reset_n)
      ctrlEn && state_q == alc_pkg::ST_RECOVER && gain_q <= ceilFine && $stable(ctrl_q) &&
      $stable(recCeil_q) && $stable(pbCeil_q) |=> gain_q <= ceilFine;
  endproperty
  a_rec_ceiling: assert property (p_rec_ceiling) // [R10]
    else $error("recovery passed the ceiling");

  property p_rec_rises;
    @(posedge clock) disable iff (!reset_n)
      smp && ctrlEn && state_q == alc_pkg::ST_RECOVER && belowRst &&
      gain_q < ceilFine |=> gain_q > $past(gain_q);
  endproperty
  a_rec_rises: assert property (p_rec_rises) // [R09]
    else $error("recovery did not raise the gain");

  property p_timer_reset;
    @(posedge clock) disable iff (!reset_n)
      smp && ctrlEn && state_q == alc_pkg::ST_RECOVER && !overDet && !belowRst
      |-> s_wait_entered;
  endproperty
  a_timer_reset: assert property (p_timer_reset) // [R12]
    else $error("mid level did not restart the wait");

  property p_readback;
    @(posedge clock) disable iff (!reset_n)
      reset_n |=> readback_q == binCode($past(gain_q[21 -: 8]));
  endproperty
  a_readback: assert property (p_readback) // [R17]
    else $error("readback does not follow the gain");

  property p_soft_release;
    @(posedge clock) disable iff (!reset_n)
      smp && !ctrlEn && gain_q < manualFine |=>
      gain_q > $past(gain_q) && gain_q - $past(gain_q) <= alc_pkg::SOFT_STEP;
  endproperty
  a_soft_release: assert property (p_soft_release) // [R20]
    else $error("release did not glide toward manual volume");

endmodule // alc_gain

`default_nettype wire

// ### inc/alc_pkg.sv
/*
  Package for the automatic level control gain block: register map, field
  positions, reset values, level thresholds, gain steps and carrier types.
  Assumes 25-bit signed samples with one bit of headroom above full scale.
*/
`default_nettype none

package alc_pkg;

  // ----------------------------------------------------------------------
  // Register map (word index on the register port)
  // ----------------------------------------------------------------------
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_REC_CEIL = 3'h1;
  localparam logic [2:0] ADDR_PB_CEIL = 3'h2;
  localparam logic [2:0] ADDR_REC_VOL = 3'h3;
  localparam logic [2:0] ADDR_PB_VOL = 3'h4;
  localparam logic [2:0] ADDR_STATUS = 3'h5;

  // ----------------------------------------------------------------------
  // Control and status word fields
  // ----------------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_PATH_BIT = 1;
  localparam int CTRL_LMTH_LSB = 2;
  localparam int CTRL_WTM_LSB = 4;
  localparam int CTRL_RGAIN_LSB = 6;
  localparam int CTRL_RFST_LSB = 9;
  localparam int STAT_FAST_BIT = 8;
  localparam int STAT_STATE_LSB = 9;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [10:0] CTRL_RESET = 11'h000;
  localparam logic [7:0] CEIL_RESET = 8'hE1;
  localparam logic [7:0] REC_VOL_RESET = 8'hE1;
  localparam logic [7:0] PB_VOL_RESET = 8'h91;

  // ----------------------------------------------------------------------
  // Sample magnitudes, full scale is 2^23
  // ----------------------------------------------------------------------
  localparam logic [24:0] LVL_P0_53 = 25'h0880D15;
  localparam logic [24:0] LVL_M1_16 = 25'h0700078;
  localparam logic [24:0] LVL_M2_5 = 25'h05FFC89;
  localparam logic [24:0] LVL_M4_1 = 25'h04FD58A;
  localparam logic [24:0] LVL_M6_0 = 25'h04026A6;
  localparam logic [24:0] LVL_M8_5 = 25'h030B48C;
  localparam logic [24:0] LVL_M12 = 25'h02026F4;

  // ----------------------------------------------------------------------
  // Gain in fine units of 0.375/16384 dB; integer part is the volume code
  // ----------------------------------------------------------------------
  localparam int FRAC_W = 14;
  localparam logic [21:0] ATT_BIG = 22'd16666;
  localparam logic [21:0] ATT_MID = 22'd2977;
  localparam logic [21:0] ATT_SMALL = 22'd1113;
  localparam logic [21:0] SOFT_STEP = 22'd4096;
  localparam int LIMIT_SAMPLES = 16;
  localparam int WAIT_BASE = 128;

  typedef enum {ST_OFF, ST_LIMIT, ST_WAIT, ST_RECOVER} alc_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [15:0] wdata;
  } alc_busreq_t;

  typedef struct packed {
    logic valid;
    logic signed [24:0] left;
    logic signed [24:0] right;
  } alc_sample_t;

  typedef struct packed {
    logic [7:0] code;
    logic [FRAC_W-1:0] frac;
  } alc_gain_t;

endpackage

`default_nettype wire

// ### testbench/alc_gain_tb.sv
/*
  Self-checking bench for the level control gain engine.
  Assumes alc_pkg and the sample source model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module alc_gain_tb;
  // --------------------------------
  // Signals
  // --------------------------------
  localparam int ONE = 1 << alc_pkg::FRAC_W;
  localparam int TMO = 30000;
  localparam logic [24:0] QUIET = 25'h0000100;
  localparam logic [24:0] BIG = alc_pkg::LVL_P0_53;
  localparam logic [24:0] MID = alc_pkg::LVL_M1_16 + 25'h0000001;
  localparam logic [24:0] LOW = alc_pkg::LVL_M1_16 - 25'h0000001;
  logic clock;
  logic reset_n;
  alc_pkg::alc_busreq_t busReq;
  logic [15:0] rdData;
  alc_pkg::alc_sample_t sampleIn;
  alc_pkg::alc_gain_t gainOut;
  logic limitActive;
  logic req;
  logic [24:0] lvl;
  logic [2:0] rnd;
  logic vld1;
  logic rd1;
  logic [23:0] gn;
  logic [31:0] rn;
  int seed = 94133;
  int errCount = 0;
  int nChecks = 0;
  int cycles = 0;
  int G;
  logic [23:0] gq[$];
  logic [31:0] rq[$];
  logic [15:0] resetTab [8] = '{16'h0000, 16'h00E1, 16'h00E1, 16'hE1E1, 16'h9191,
    16'h0091, 16'h0000, 16'h0000};
  logic [24:0] detTab [4] = '{alc_pkg::LVL_M2_5, alc_pkg::LVL_M4_1, alc_pkg::LVL_M6_0,
    alc_pkg::LVL_M8_5};
  int stepTab [8] = '{183, 92, 48, 22, 13, 4, 3, 1};

  alc_gain alc_gain_i (.clock(clock), .reset_n(reset_n), .busReq(busReq), .rdData(rdData),
    .sampleIn(sampleIn), .gainOut(gainOut), .limitActive(limitActive));
  alc_sample_src alc_sample_src_i (.clock(clock), .reset_n(reset_n), .req(req),
    .level(lvl), .rnd(rnd), .sampleOut(sampleIn));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // --------------------------------
  // Tasks
  // --------------------------------
  task automatic finalReport;
    if (errCount == 0 && nChecks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cmpGain(input logic [22:0] got, input logic [22:0] exp);
    nChecks++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] %0t gain got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmpRd(input logic [15:0] got, input logic [15:0] exp);
    nChecks++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] %0t read got %h exp %h", $time, got, exp);
    end
  endtask

  // Note holds check flag, limiter flag and expected gain
  task automatic send(input logic [24:0] l, input int d, input logic lim, input logic chk);
    G = G + d;
    gq.push_back({chk, lim, G[21:0]});
    lvl <= l;
    rnd <= 3'($random(seed));
    req <= 1'b1;
    @(posedge clock);
    req <= 1'b0;
    @(posedge clock);
  endtask

  task automatic busWrite(input logic [2:0] a, input logic [15:0] d);
    busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    busReq <= '0;
    @(posedge clock);
  endtask

  // Extra leading edge lets the registered readback catch up
  task automatic busRead(input logic [2:0] a, input logic [15:0] m, input logic [15:0] e);
    rq.push_back({m, e & m});
    @(posedge clock);
    busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clock);
    busReq <= '0;
    @(posedge clock);
  endtask

  task automatic limit16(input logic [24:0] l, input int att);
    for (int i = 0; i < 16; i++) begin
      send(l, -att, i < 15, 1'b1);
    end
  endtask

  task automatic quiet(input int n);
    repeat (n) send(QUIET, 0, 1'b0, 1'b1);
  endtask

  task automatic rise(input int n, input int step, input int ceil);
    int d;
    repeat (n) begin
      d = ceil * ONE - G;
      send(QUIET, d < step ? d : step, 1'b0, 1'b1);
    end
  endtask

  task automatic glide(input int n, input int code);
    int d;
    int s;
    s = alc_pkg::SOFT_STEP;
    repeat (n) begin
      d = code * ONE - G;
      d = d > s ? s : (d < -s ? -s : d);
      send(QUIET, d, 1'b0, 1'b1);
    end
  endtask

  function automatic logic [15:0] binOf(input int g);
    int c;
    c = g >>> alc_pkg::FRAC_W;
    if (c == 0) return 16'h0000;
    if (c < 17) return 16'h0001;
    if (c < 25) return 16'h0011;
    if (c < 33) return 16'h0019;
    if (c > 239) return 16'h00ED;
    return 16'(33 + ((c - 33) & ~3));
  endfunction

  // --------------------------------
  // Monitor and timeout
  // --------------------------------
  always @(posedge clock) begin
    vld1 <= sampleIn.valid;
    rd1 <= busReq.rd;
    cycles <= cycles + 1;
    if (cycles == TMO) begin
      errCount++;
      finalReport();
    end
  end

  always @(negedge clock) begin
    if (vld1 === 1'b1) begin
      gn = gq.pop_front();
      if (gn[23]) cmpGain({limitActive, gainOut}, gn[22:0]);
    end
    if (rd1 === 1'b1) begin
      rn = rq.pop_front();
      cmpRd(rdData & rn[31:16], rn[15:0]);
    end
  end

  // --------------------------------
  // Sequence
  // --------------------------------
  initial begin
    logic [15:0] v;
    reset_n = 1'b0;
    busReq = '0;
    req = 1'b0;
    lvl = '0;
    rnd = '0;
    G = 145 * ONE;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    @(negedge clock);
    cmpGain({limitActive, gainOut}, {1'b0, G[21:0]});
    for (int a = 0; a < 8; a++) begin
      busRead(3'(a), 16'hFFFF, resetTab[a]);
    end
    v = 16'($random(seed)) & 16'h07FE;
    busWrite(alc_pkg::ADDR_CTRL, v);
    busRead(alc_pkg::ADDR_CTRL, 16'hFFFF, v);
    busWrite(alc_pkg::ADDR_CTRL, 16'h0000);
    repeat (3) send(BIG, 0, 1'b0, 1'b1);
    busWrite(alc_pkg::ADDR_REC_VOL, 16'h9090);
    busWrite(alc_pkg::ADDR_CTRL, 16'h0002);
    glide(5, 144);
    busWrite(alc_pkg::ADDR_CTRL, 16'h0000);
    glide(5, 145);
    for (int t = 0; t < 4; t++) begin
      v = 16'(t << alc_pkg::CTRL_LMTH_LSB);
      busWrite(alc_pkg::ADDR_CTRL, v | 16'h0001);
      quiet(1);
      send(detTab[t], 0, 1'b0, 1'b1);
      limit16(detTab[t] + 25'h0000001, alc_pkg::ATT_SMALL);
      busWrite(alc_pkg::ADDR_CTRL, v);
      glide(6, 145);
    end
    busWrite(alc_pkg::ADDR_CTRL, 16'h0001);
    quiet(1);
    limit16(BIG, alc_pkg::ATT_BIG);
    limit16(MID, alc_pkg::ATT_MID);
    limit16(LOW, alc_pkg::ATT_SMALL);
    busRead(alc_pkg::ADDR_STATUS, 16'h06FF, 16'h0400 | binOf(G));
    quiet(100);
    send(alc_pkg::LVL_M4_1, 0, 1'b0, 1'b1);
    quiet(100);
    busRead(alc_pkg::ADDR_STATUS, 16'h0600, 16'h0400);
    busWrite(alc_pkg::ADDR_CTRL, 16'h0000);
    glide(90, 145);
    for (int k = 0; k < 8; k++) begin
      v = 16'((k << alc_pkg::CTRL_RGAIN_LSB) | ((k % 4) << alc_pkg::CTRL_WTM_LSB));
      busWrite(alc_pkg::ADDR_CTRL, v | 16'h0001);
      quiet(1);
      limit16(LOW, alc_pkg::ATT_SMALL);
      quiet(alc_pkg::WAIT_BASE << (k % 4));
      rise(4, stepTab[k], 225);
      busRead(alc_pkg::ADDR_STATUS, 16'h06FF, 16'h0600 | binOf(G));
      busWrite(alc_pkg::ADDR_CTRL, v);
      glide(6, 145);
    end
    busWrite(alc_pkg::ADDR_PB_CEIL, 16'h0091);
    busWrite(alc_pkg::ADDR_CTRL, 16'h0001);
    quiet(1);
    limit16(BIG, alc_pkg::ATT_BIG);
    quiet(alc_pkg::WAIT_BASE);
    rise(1470, stepTab[0], 145);
    busRead(alc_pkg::ADDR_STATUS, 16'h06FF, 16'h0691);
    busRead(alc_pkg::ADDR_REC_CEIL, 16'hFFFF, 16'h00E1);
    quiet(1);
    send(BIG, -int'(alc_pkg::ATT_BIG), 1'b1, 1'b1);
    send(QUIET, -int'(alc_pkg::ATT_SMALL), 1'b1, 1'b1);
    repeat (13) send(BIG, -int'(alc_pkg::ATT_BIG), 1'b1, 1'b1);
    send(BIG, -int'(alc_pkg::ATT_BIG), 1'b0, 1'b1);
    busRead(alc_pkg::ADDR_STATUS, 16'h0100, 16'h0100);
    quiet(alc_pkg::WAIT_BASE);
    // Fast select 00 is 0.0032 dB, 140 fine units
    rise(4, 140, 145);
    busWrite(alc_pkg::ADDR_CTRL, 16'h0000);
    glide(90, 145);
    G = 145 * ONE;
    quiet(2);
    @(posedge clock);
    finalReport();
  end
endmodule // alc_gain_tb

`default_nettype wire

// ### testbench/alc_sample_src.sv
/*
  Sample source standing in for the upstream filter stage of the path.
  Assumes the bench raises req just after a rising edge, one cycle long.
*/
`timescale 1ns/1ps
`default_nettype none

module alc_sample_src (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic req,
  input wire logic [24:0] level,
  input wire logic [2:0] rnd,
  output var alc_pkg::alc_sample_t sampleOut
);
  // --------------------------------
  // Sample launch
  // --------------------------------
  logic signed [24:0] peak;
  logic signed [24:0] half;
  assign peak = rnd[0] ? -$signed(level) : $signed(level);
  assign half = rnd[1] ? -$signed(level >> 1) : $signed(level >> 1);

  always @(posedge clock) begin
    if (!reset_n) begin
      sampleOut <= '0;
    end else if (req) begin
      sampleOut.valid <= 1'b1;
      // Either channel may carry the peak
      sampleOut.left <= rnd[2] ? peak : half;
      sampleOut.right <= rnd[2] ? half : peak;
    end else begin
      // Stale data flips, never looks held
      sampleOut.valid <= 1'b0;
      sampleOut.left <= ~sampleOut.left;
      sampleOut.right <= ~sampleOut.right;
    end
  end
endmodule // alc_sample_src

`default_nettype wire
